// ===== rtl/amt_regs.sv
// Purpose: Alarm mask, lane FIFO alarm, alarm status and timing trim registers on APB.
// Assumes: Single clock; synchronous active-high reset; alarm inputs are levels.
// Notes: APB answers in the access phase with no wait state.
// Contract
// (R1) Set mask bit keeps alarm out of summary.
// (R2) Mask resets to 0x3f, top bits zero.
// (R3) Lane bit sets on that lane's error.
// (R4) Writing one clears lane bit; zero keeps.
// (R5) Persisting lane error sets bit again.
// (R6) Status FIFO bit write clears all lanes.
// (R7) Lane alarm register resets to all ones.
// (R8) Trim registers are 8-bit read/write.
// (R9) Trims load factory values at reset.
// (R10) Dual mode uses 0x310 and 0x313.
// (R11) Single mode input A uses 0x314, 0x315.
// (R12) Mode and input select the applied trim.
// (R13) Summary is one if unmasked status set.
// (R14) Status bits write-one-clear, reset all set.
// (R15) Mask change reaches summary next cycle.
`timescale 1ns/1ps
`include "amt_defines.svh"
module amt_regs #(
    parameter int ADDR_W = 12
) (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // APB slave.
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    // Alarm conditions, levels.
    input wire logic [`AMT_ALARMS-2:0] alarm_event_in,
    input wire logic [`AMT_LANES-1:0] lane_fifo_err_in,
    // Factory trim values.
    input wire logic [7:0] trim_fuse_in [`AMT_TRIMS],
    // Core timing trims and alarm interrupt.
    output logic [7:0] core_a_trim_out,
    output logic [7:0] core_b_trim_out,
    output logic core_trim_valid_out,
    output logic irq_out
);
    localparam logic [`AMT_LANES-1:0] LANE_RST = `AMT_LANE_RST;
    localparam logic [7:0] STATUS_RST = `AMT_STATUS_RST;

    amt_trim_if tif ();

    logic [7:0] alarm_status_q;
    logic [7:0] alarm_mask_q;
    logic [`AMT_LANES-1:0] lane_fifo_alarm_q;
    logic [2:0] ctrl_q;
    amt_pkg::amt_trim_t trim_q [`AMT_TRIMS];
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [9:0] idx;
    logic aligned;
    logic setup;
    logic wr_acc;
    logic [31:0] rd_d;
    logic hit_d;
    logic wr_status;
    logic wr_mask;
    logic wr_lane;
    logic wr_ctrl;
    logic bulk_clr;
    logic [7:0] events;
    logic [`AMT_TRIMS-1:0] wr_trim;
    logic [9:0] trim_idx [`AMT_TRIMS];

    // Decode of the word index; misaligned addresses hit nothing.
    assign idx = paddr_in[11:2];
    assign aligned = (paddr_in[1:0] == 2'h0);
    assign setup = psel_in && !penable_in;
    assign wr_acc = psel_in && penable_in && pwrite_in && aligned;
    assign wr_status = wr_acc && (idx == `AMT_IDX_STATUS);
    assign wr_mask = wr_acc && (idx == `AMT_IDX_MASK);
    assign wr_lane = wr_acc && (idx == `AMT_IDX_LANE);
    assign wr_ctrl = wr_acc && (idx == `AMT_IDX_CTRL);
    assign bulk_clr = wr_status && pwdata_in[`AMT_FIFO_BIT]; // [R6]
    assign trim_idx[`AMT_SLOT_A_DUAL] = `AMT_IDX_TRIM_A_DUAL;
    assign trim_idx[`AMT_SLOT_B_DUAL] = `AMT_IDX_TRIM_B_DUAL;
    assign trim_idx[`AMT_SLOT_A_SGL] = `AMT_IDX_TRIM_A_SGL;
    assign trim_idx[`AMT_SLOT_B_SGL] = `AMT_IDX_TRIM_B_SGL;

    // Read mux; unused bits read as zero, the reserved mask top bits read back as written.
    always_comb begin
        rd_d = '0;
        hit_d = aligned;
        unique case (idx)
            `AMT_IDX_SUMMARY: rd_d[0] = irq_out; // [R13]
            `AMT_IDX_STATUS: rd_d[7:0] = alarm_status_q;
            `AMT_IDX_MASK: rd_d[7:0] = alarm_mask_q;
            `AMT_IDX_LANE: rd_d[`AMT_LANES-1:0] = lane_fifo_alarm_q;
            `AMT_IDX_CTRL: rd_d[2:0] = ctrl_q;
            `AMT_IDX_TRIM_A_DUAL: rd_d[7:0] = trim_q[`AMT_SLOT_A_DUAL]; // [R9]
            `AMT_IDX_TRIM_B_DUAL: rd_d[7:0] = trim_q[`AMT_SLOT_B_DUAL];
            `AMT_IDX_TRIM_A_SGL: rd_d[7:0] = trim_q[`AMT_SLOT_A_SGL];
            `AMT_IDX_TRIM_B_SGL: rd_d[7:0] = trim_q[`AMT_SLOT_B_SGL];
            default: hit_d = 1'b0;
        endcase
        if (!aligned) begin
            rd_d = '0;
        end
    end

    // Read data and error are captured in the setup phase so they come from flops.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= pwrite_in ? 32'h0 : rd_d;
            pslverr_q <= !hit_d;
        end
    end

    // Zero wait states; an error answer leaves every register unchanged.
    assign pready_out = 1'b1;
    assign prdata_out = prdata_q;
    assign pslverr_out = psel_in && penable_in && pslverr_q;

    // Status sources; the FIFO bit follows any lane in trouble.
    assign events = {2'h0, |lane_fifo_err_in, alarm_event_in};

    // Alarm status, write one to clear; a new event wins over the clear. [R14]
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alarm_status_q <= `AMT_STATUS_RST; // [R14]
        end else if (wr_status) begin
            alarm_status_q <= (alarm_status_q & ~pwdata_in[7:0]) | events;
        end else begin
            alarm_status_q <= alarm_status_q | events;
        end
    end

    // Alarm mask, plain read/write including the reserved top bits.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            alarm_mask_q <= `AMT_MASK_RST; // [R2]
        end else if (wr_mask) begin
            alarm_mask_q <= pwdata_in[7:0];
        end
    end

    // Summary alarm drives the interrupt straight from the flops, so a mask write
    // shows at the next edge with no extra stage. [R1] [R13] [R15]
    assign irq_out = |(alarm_status_q[`AMT_ALARMS-1:0] & ~alarm_mask_q[`AMT_ALARMS-1:0]);

    // Per-lane alarm: sticky set, write-one clear, bulk clear; set wins. [R3] [R4] [R5]
    for (genvar i = 0; i < `AMT_LANES; i++) begin : g_lane
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                lane_fifo_alarm_q[i] <= LANE_RST[i]; // [R7]
            end else if (lane_fifo_err_in[i]) begin
                lane_fifo_alarm_q[i] <= 1'b1; // [R3] [R5]
            end else if (bulk_clr || (wr_lane && pwdata_in[i])) begin
                lane_fifo_alarm_q[i] <= 1'b0; // [R4] [R6]
            end
        end
    end

    // Channel setup: dual mode, input B select, foreground calibration enable.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            ctrl_q <= `AMT_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_q <= pwdata_in[2:0];
        end
    end

    // Trim registers take factory values while reset is held, then software
    // may overwrite them. [R8] [R9]
    for (genvar t = 0; t < `AMT_TRIMS; t++) begin : g_trim
        assign wr_trim[t] = wr_acc && (idx == trim_idx[t]);
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                trim_q[t] <= trim_fuse_in[t]; // [R9]
            end else if (wr_trim[t]) begin
                trim_q[t] <= pwdata_in[7:0]; // [R8]
            end
        end
        assign tif.trim[t] = trim_q[t];
    end

    // Selector hookup; the selector registers the applied trims. [R12]
    assign tif.dual_mode = ctrl_q[`AMT_CTRL_DUAL];
    assign tif.input_b = ctrl_q[`AMT_CTRL_INB];
    assign tif.fg_cal_en = ctrl_q[`AMT_CTRL_FG];

    amt_trim_sel u_sel (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .tif(tif.sel)
    );

    assign core_a_trim_out = tif.core_a;
    assign core_b_trim_out = tif.core_b;
    assign core_trim_valid_out = tif.valid;

    // Checks on the bank's own behaviour.
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence lane_w1c_s;
        wr_lane && !bulk_clr && (lane_fifo_err_in == '0);
    endsequence
    sequence lane_w1c_busy_s;
        wr_lane && (pwdata_in[`AMT_LANES-1:0] & lane_fifo_err_in) != '0;
    endsequence
    sequence bulk_s;
        bulk_clr && (lane_fifo_err_in == '0);
    endsequence

    mask_gate_a: assert property ( // [R1]
        ((alarm_status_q[`AMT_ALARMS-1:0] & ~alarm_mask_q[`AMT_ALARMS-1:0]) == '0) |-> !irq_out)
        else $error("Masked alarm reached summary.");
    // An unmasked event must reach the summary through the sticky status bit.
    summary_set_a: assert property ( // [R13]
        (events[`AMT_ALARMS-1:0] & ~alarm_mask_q[`AMT_ALARMS-1:0]) != '0 && !wr_mask
        |=> irq_out)
        else $error("Unmasked alarm missing from summary.");
    summary_read_a: assert property ( // [R13]
        setup && !pwrite_in && aligned && idx == `AMT_IDX_SUMMARY |=>
        prdata_q == {31'h0, $past(irq_out)})
        else $error("Summary bit read back wrong.");
    // Reset values are looked at on the first edge after release, when the
    // flops have surely been through at least one reset edge.
    mask_reset_a: assert property (disable iff (1'b0) // [R2]
        $past(rst_in) && !rst_in |-> alarm_mask_q == `AMT_MASK_RST)
        else $error("Mask reset value wrong.");
    status_reset_a: assert property (disable iff (1'b0) // [R14]
        $past(rst_in) && !rst_in |-> alarm_status_q == STATUS_RST)
        else $error("Status reset value wrong.");
    lane_reset_a: assert property (disable iff (1'b0) // [R7]
        $past(rst_in) && !rst_in |-> lane_fifo_alarm_q == LANE_RST)
        else $error("Lane alarm reset value wrong.");
    lane_set_a: assert property ( // [R3]
        lane_fifo_err_in != '0 |=> (lane_fifo_alarm_q & $past(lane_fifo_err_in))
        == $past(lane_fifo_err_in))
        else $error("Lane error did not set its alarm.");
    lane_clear_a: assert property (lane_w1c_s |=> // [R4]
        lane_fifo_alarm_q == ($past(lane_fifo_alarm_q) & ~$past(pwdata_in[`AMT_LANES-1:0])))
        else $error("Lane write-one clear wrong.");
    lane_retrip_a: assert property (lane_w1c_busy_s |=> // [R5]
        (lane_fifo_alarm_q & $past(lane_fifo_err_in)) == $past(lane_fifo_err_in))
        else $error("Persisting lane error was lost.");
    bulk_clear_a: assert property (bulk_s |=> lane_fifo_alarm_q == '0) // [R6]
        else $error("Status FIFO write did not clear lanes.");
    trim_write_a: assert property ( // [R8]
        wr_acc && idx == `AMT_IDX_TRIM_B_DUAL |=>
        trim_q[`AMT_SLOT_B_DUAL] == $past(pwdata_in[7:0]))
        else $error("Trim write not stored.");
    trim_fuse_a: assert property (disable iff (1'b0) // [R9]
        $past(rst_in) && !rst_in |->
        trim_q[`AMT_SLOT_A_SGL] == $past(trim_fuse_in[`AMT_SLOT_A_SGL]))
        else $error("Trim not loaded from factory value.");
    mask_latency_a: assert property ( // [R15]
        wr_mask && pwdata_in[`AMT_ALARMS-1:0] == '1 |=> !irq_out)
        else $error("Mask write late in summary.");
endmodule

// ===== rtl/amt_defines.svh
// Purpose: Register indices, reset values and field positions of the alarm and trim bank.
// Assumes: Byte address of a register is four times its index.
// Notes: Definitions only.
`ifndef AMT_DEFINES_SVH
`define AMT_DEFINES_SVH

// Register indices; byte address is index times four.
`define AMT_IDX_SUMMARY 10'h2c0
`define AMT_IDX_STATUS 10'h2c1
`define AMT_IDX_MASK 10'h2c2
`define AMT_IDX_LANE 10'h2c4
`define AMT_IDX_CTRL 10'h2c6
`define AMT_IDX_TRIM_A_DUAL 10'h310
`define AMT_IDX_TRIM_B_DUAL 10'h313
`define AMT_IDX_TRIM_A_SGL 10'h314
`define AMT_IDX_TRIM_B_SGL 10'h315

// Reset values.
`define AMT_STATUS_RST 8'h3f
`define AMT_MASK_RST 8'h3f
`define AMT_LANE_RST 16'hffff
`define AMT_CTRL_RST 3'h5

// Widths and field positions.
`define AMT_ALARMS 6
`define AMT_LANES 16
`define AMT_TRIMS 4
`define AMT_FIFO_BIT 5
`define AMT_CTRL_DUAL 0
`define AMT_CTRL_INB 1
`define AMT_CTRL_FG 2
`define AMT_SLOT_A_DUAL 0
`define AMT_SLOT_B_DUAL 1
`define AMT_SLOT_A_SGL 2
`define AMT_SLOT_B_SGL 3

`endif

// ===== rtl/amt_pkg.sv
// Purpose: Types shared by the alarm and trim bank modules.
// Assumes: Nothing beyond the defines header.
// Notes: No constants live here; numbers are in the defines header.
package amt_pkg;
    typedef logic [7:0] amt_trim_t;
    typedef enum logic [1:0] {
        AMT_MODE_DUAL,
        AMT_MODE_SINGLE_A,
        AMT_MODE_OTHER
    } amt_mode_e;
endpackage

// ===== rtl/amt_trim_if.sv
// Purpose: Carries trim values and channel setup to the trim selector and its answer back.
// Assumes: One clock domain.
// Notes: The register bank drives the setup; the selector drives the results.
`timescale 1ns/1ps
`include "amt_defines.svh"
interface amt_trim_if;
    logic dual_mode;
    logic input_b;
    logic fg_cal_en;
    amt_pkg::amt_trim_t trim [`AMT_TRIMS];
    amt_pkg::amt_trim_t core_a;
    amt_pkg::amt_trim_t core_b;
    logic valid;
    modport regs (output dual_mode, input_b, fg_cal_en, trim, input core_a, core_b, valid);
    modport sel (input dual_mode, input_b, fg_cal_en, trim, output core_a, core_b, valid);
endinterface

// ===== rtl/amt_trim_sel.sv
// Purpose: Picks the timing trim that each converter core applies.
// Assumes: Setup and trims come from flip-flops of the register bank.
// Notes: Outputs are registered, so a change is applied one cycle after it is stored.
`timescale 1ns/1ps
`include "amt_defines.svh"
module amt_trim_sel (
    // Clock and reset.
    input wire logic clk_in,
    input wire logic rst_in,
    // Setup in, selection out.
    amt_trim_if.sel tif
);
    amt_pkg::amt_mode_e mode;
    amt_pkg::amt_trim_t core_a_d;
    amt_pkg::amt_trim_t core_b_d;
    logic valid_d;

    // Current mode; single channel on input B and uncalibrated operation apply no trim and drop valid.
    always_comb begin
        if (!tif.fg_cal_en) begin
            mode = amt_pkg::AMT_MODE_OTHER;
        end else if (tif.dual_mode) begin
            mode = amt_pkg::AMT_MODE_DUAL;
        end else if (!tif.input_b) begin
            mode = amt_pkg::AMT_MODE_SINGLE_A;
        end else begin
            mode = amt_pkg::AMT_MODE_OTHER;
        end
    end

    // Only the trims that match the mode reach the cores. [R12]
    always_comb begin
        core_a_d = '0;
        core_b_d = '0;
        valid_d = 1'b0;
        unique case (mode)
            amt_pkg::AMT_MODE_DUAL: begin
                core_a_d = tif.trim[`AMT_SLOT_A_DUAL]; // [R10]
                core_b_d = tif.trim[`AMT_SLOT_B_DUAL]; // [R10]
                valid_d = 1'b1;
            end
            amt_pkg::AMT_MODE_SINGLE_A: begin
                core_a_d = tif.trim[`AMT_SLOT_A_SGL]; // [R11]
                core_b_d = tif.trim[`AMT_SLOT_B_SGL]; // [R11]
                valid_d = 1'b1;
            end
            amt_pkg::AMT_MODE_OTHER: begin
                valid_d = 1'b0;
            end
        endcase
    end

    // Registered selection so the core sees a glitch-free value.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            tif.core_a <= '0;
            tif.core_b <= '0;
            tif.valid <= 1'b0;
        end else begin
            tif.core_a <= core_a_d;
            tif.core_b <= core_b_d;
            tif.valid <= valid_d;
        end
    end

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    dual_pick_a: assert property (tif.fg_cal_en && tif.dual_mode |=> // [R10]
        tif.valid && tif.core_a == $past(tif.trim[`AMT_SLOT_A_DUAL])
        && tif.core_b == $past(tif.trim[`AMT_SLOT_B_DUAL]))
        else $error("Dual mode trim not selected.");
    single_pick_a: assert property (tif.fg_cal_en && !tif.dual_mode && !tif.input_b |=> // [R11]
        tif.valid && tif.core_a == $past(tif.trim[`AMT_SLOT_A_SGL])
        && tif.core_b == $past(tif.trim[`AMT_SLOT_B_SGL]))
        else $error("Single mode input A trim not selected.");
    other_none_a: assert property (!tif.fg_cal_en || (!tif.dual_mode && tif.input_b) |=> // [R12]
        !tif.valid) else $error("Trim applied in an unsupported mode.");
endmodule

// ===== test/test_amt_regs.sv
// Purpose: Self-checking bench for the alarm mask, lane alarm and timing trim bank.
// Assumes: Zero-wait APB slave; byte address is four times the register index.
// Notes: Random data come from a fixed-seed xorshift, so every run is the same.
`timescale 1ns/1ps
`include "amt_defines.svh"
module test_amt_regs;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [4:0] alarm_ev = 5'h00;
    logic [15:0] lane_err = 16'h0000;
    logic [7:0] fuse [4];
    logic [7:0] trim [4];
    logic [7:0] core_a;
    logic [7:0] core_b;
    logic core_valid;
    logic irq;
    logic [31:0] seed = 32'h9113a436;
    logic [31:0] rd;
    logic [31:0] v;
    logic er;
    int err_count = 0;
    int checks = 0;

    // Free-running 20 MHz clock.
    always #25 clk_in = ~clk_in;

    amt_regs u_dut (.clk_in(clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
        .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
        .pready_out(pready), .pslverr_out(pslverr), .alarm_event_in(alarm_ev),
        .lane_fifo_err_in(lane_err), .trim_fuse_in(fuse), .core_a_trim_out(core_a),
        .core_b_trim_out(core_b), .core_trim_valid_out(core_valid), .irq_out(irq));

    // Xorshift source; the module-level state keeps the sequence repeatable.
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected {valid, core A, core B} for a control value {fg, input_b, dual}.
    function automatic logic [16:0] exp_core(input logic [2:0] ctrl);
        if (ctrl[2] && ctrl[0]) begin
            return {1'b1, trim[0], trim[1]};
        end
        if (ctrl[2] && !ctrl[1]) begin
            return {1'b1, trim[2], trim[3]};
        end
        return 17'h00000;
    endfunction

    task automatic finish_test();
        if (err_count == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %h want %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected at %0t: %s got %b want %b", $time, msg, got, exp);
        end
    endtask

    // One APB transfer; the request stands until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rdata, output logic err);
        int n;
        n = 0;
        @(posedge clk_in);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'b1;
        // Ready, read data and error are all taken at the same rising edge.
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            err_count++;
            finish_test();
        end
        rdata = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        logic e;
        apb(1'b1, idx, wd, d, e);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input string msg);
        logic e;
        apb(1'b0, idx, 32'h0, rd, e);
        chk_word(rd, exp, msg);
    endtask

    // The interrupt is looked at once the previous edge's updates have landed.
    task automatic irq_chk(input logic exp);
        @(negedge clk_in);
        chk_bit(irq, exp, "irq");
    endtask

    task automatic core_chk(input logic [2:0] ctrl);
        @(negedge clk_in);
        chk_word({15'h0000, core_valid, core_a, core_b}, {15'h0000, exp_core(ctrl)}, "cores");
    endtask

    // Hard stop for a hung run.
    initial begin
        #(50 * 60000);
        err_count++;
        finish_test();
    end

    initial begin
        logic [2:0] modes [6];
        modes = '{3'h5, 3'h4, 3'h6, 3'h1, 3'h0, 3'h7};
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            fuse[i] = v[7:0];
            trim[i] = v[7:0];
        end
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        irq_chk(1'b0);
        core_chk(3'h5);
        rd_chk(`AMT_IDX_MASK, 32'h3f, "mask reset");
        rd_chk(`AMT_IDX_LANE, 32'hffff, "lane reset");
        rd_chk(`AMT_IDX_STATUS, 32'h3f, "status reset");
        for (int i = 0; i < 4; i++) begin
            rd_chk(`AMT_IDX_TRIM_A_DUAL + (i == 1 ? 3 : i == 2 ? 4 : i == 3 ? 5 : 0),
                   {24'h0, fuse[i]}, "trim reset");
        end
        // Unmasking everything with all status bits set raises the summary at once.
        wr(`AMT_IDX_MASK, 32'hc0);
        irq_chk(1'b1);
        rd_chk(`AMT_IDX_MASK, 32'hc0, "mask rw");
        rd_chk(`AMT_IDX_SUMMARY, 32'h1, "summary");
        wr(`AMT_IDX_STATUS, 32'hff);
        rd_chk(`AMT_IDX_STATUS, 32'h0, "status w1c");
        rd_chk(`AMT_IDX_LANE, 32'h0, "lane bulk early");
        irq_chk(1'b0);
        // Each event alarm 0 to 4 in turn: only its own mask bit decides the summary.
        for (int k = 0; k < 5; k++) begin
            @(posedge clk_in);
            alarm_ev <= 5'(1 << k);
            @(posedge clk_in);
            alarm_ev <= 5'h00;
            rd_chk(`AMT_IDX_STATUS, 32'(1 << k), "status set");
            wr(`AMT_IDX_MASK, 32'(~(1 << k) & 32'h3f));
            irq_chk(1'b1);
            wr(`AMT_IDX_MASK, 32'(1 << k));
            irq_chk(1'b0);
            wr(`AMT_IDX_STATUS, 32'(1 << k));
        end
        // Lane alarms: random partial clears, a persisting error, then bulk clear.
        // The status write above cleared every lane, so all lanes are tripped first.
        @(posedge clk_in);
        lane_err <= 16'hffff;
        @(posedge clk_in);
        lane_err <= 16'h0000;
        v = rnd() & 32'hffff;
        wr(`AMT_IDX_LANE, v);
        rd_chk(`AMT_IDX_LANE, ~v & 32'hffff, "lane w1c");
        wr(`AMT_IDX_LANE, 32'hffff);
        v = rnd() & 32'hffff;
        @(posedge clk_in);
        lane_err <= v[15:0];
        @(posedge clk_in);
        lane_err <= 16'h0000;
        rd_chk(`AMT_IDX_LANE, v, "lane set");
        v = 32'(1 << (rnd() % 16));
        lane_err <= v[15:0];
        wr(`AMT_IDX_LANE, 32'hffff);
        rd_chk(`AMT_IDX_LANE, v, "lane persist");
        lane_err <= 16'h0000;
        wr(`AMT_IDX_LANE, v);
        v = rnd() & 32'hffff;
        lane_err <= v[15:0];
        @(posedge clk_in);
        lane_err <= 16'h0000;
        rd_chk(`AMT_IDX_STATUS, 32'h20, "fifo flag");
        irq_chk(1'b1);
        // Masking every alarm must drop a pending summary at the next edge.
        wr(`AMT_IDX_MASK, 32'h3f);
        irq_chk(1'b0);
        wr(`AMT_IDX_STATUS, 32'h20);
        rd_chk(`AMT_IDX_LANE, 32'h0, "lane bulk");
        // Trim read/write and the selection in control settings 5, 4, 6, 1, 0 and 7.
        for (int i = 0; i < 4; i++) begin
            v = rnd();
            trim[i] = v[7:0];
            wr(`AMT_IDX_TRIM_A_DUAL + (i == 1 ? 3 : i == 2 ? 4 : i == 3 ? 5 : 0), v);
            rd_chk(`AMT_IDX_TRIM_A_DUAL + (i == 1 ? 3 : i == 2 ? 4 : i == 3 ? 5 : 0),
                   {24'h0, trim[i]}, "trim rw");
        end
        for (int m = 0; m < 6; m++) begin
            wr(`AMT_IDX_CTRL, {29'h0, modes[m]});
            @(posedge clk_in);
            core_chk(modes[m]);
        end
        // An unmapped index is refused and reads zero.
        apb(1'b0, 10'h2c3, 32'h0, rd, er);
        chk_bit(er, 1'b1, "unmapped err");
        chk_word(rd, 32'h0, "unmapped data");
        finish_test();
    end
endmodule
